// ### psfm_pkg.sv
package psfm_pkg;
  // Fault codes sent to the controller.
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_BIAS = 3'h1;
  localparam logic [2:0] FC_BOOST = 3'h2;
  localparam logic [2:0] FC_HS_SHORT = 3'h3;
  localparam logic [2:0] FC_LS_SHORT = 3'h4;
  localparam logic [2:0] FC_OVERTEMP = 3'h5;
  // Clock and recovery timing.
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned RECOVER_NS = 37000;
  localparam int unsigned RECOVER_CYCLES = (RECOVER_NS * 1000) / CLK_PERIOD_PS;
  // Register map.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam logic [0:0] CTRL_RESET = 1'h0;
  localparam int unsigned EV_BITS = 9;
endpackage

// ### psfm_fault_manager.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module psfm_fault_manager
  import psfm_pkg::*;
#(
  parameter int unsigned RECOVER_COUNT = RECOVER_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        boost_supply_lockout,
  input  wire logic        bias_supply_lockout,
  input  wire logic        input_supply_lockout,
  input  wire logic        valley_source_limit,
  input  wire logic        sink_current_limit,
  input  wire logic        peak_source_limit,
  input  wire logic        high_side_short,
  input  wire logic        low_side_short,
  input  wire logic        powerup_check,
  input  wire logic        overtemp,
  input  wire logic        hs_on,
  input  wire logic        ls_on,
  input  wire logic        hs_request,
  input  wire logic        ls_request,
  output logic             hs_gate,
  output logic             ls_gate,
  output logic             switching_enable,
  output logic             temp_fault_line_low,
  output logic [2:0]       fault_code,
  output logic             fault_latched,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Elaboration check: the recovery down-counter is 16 bits wide and must run at least once.
  if (RECOVER_COUNT < 1 || RECOVER_COUNT > 65535) begin : g_bad_count
    $error("RECOVER_COUNT out of range");
  end

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_RECOVER, ST_LATCHED} psfm_state_type;

  // Fault pins come from analog detectors, so each passes three synchroniser flops and a filter flop.
  localparam int unsigned NPIN = 12;
  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] flt;
  assign raw = {boost_supply_lockout, ls_on, hs_on, overtemp, powerup_check, low_side_short, high_side_short,
                peak_source_limit, sink_current_limit, valley_source_limit,
                input_supply_lockout, bias_supply_lockout};

  // Synchroniser chain; the filtered value only moves when the later stages agree.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_filt
      always_ff @(posedge core_clk) begin
        if (rst) begin
          flt[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          flt[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  logic boost_f;
  logic bias_f;
  logic input_f;
  logic valley_f;
  logic sink_f;
  logic peak_f;
  logic hss_f;
  logic lss_f;
  logic pucheck_f;
  logic ot_f;
  logic hson_f;
  logic lson_f;
  assign {boost_f, lson_f, hson_f, ot_f, pucheck_f, lss_f, hss_f, peak_f, sink_f, valley_f,
          input_f, bias_f} = flt;

  // Classify faults; the short checks qualify on which switch is on, the low-side one also on the power-up check.
  logic hs_short_ev;
  logic ls_short_ev;
  logic latch_ev;
  logic nonlatch_cond;
  assign hs_short_ev = hss_f && hson_f;
  assign ls_short_ev = lss_f && (lson_f || pucheck_f);
  assign latch_ev = boost_f || hs_short_ev || ls_short_ev || ot_f;
  assign nonlatch_cond = bias_f || input_f;

  // Code chosen for a new latched fault; earlier entries win on coincidence.
  function automatic logic [2:0] latch_code(input logic bst, input logic hs, input logic ls,
                                            input logic pu, input logic ot);
    if (bst) begin
      latch_code = FC_BOOST;
    end else if (hs) begin
      latch_code = FC_HS_SHORT;
    end else if (ls) begin
      latch_code = pu ? FC_NONE : FC_LS_SHORT;
    end else if (ot) begin
      latch_code = FC_OVERTEMP;
    end else begin
      latch_code = FC_NONE;
    end
  endfunction

  psfm_state_type state;
  logic [15:0] rec_cnt;
  logic valley_source_limit_hold;

  // Fault state machine. A latched shutdown leaves only by reset, which stands for the
  // bias power cycle; a cause still present after it latches again at once.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_RUN;
      rec_cnt <= '0;
      fault_code <= FC_NONE;
    end else begin
      unique case (state)
        ST_RUN, ST_HOLD, ST_RECOVER: begin
          if (latch_ev) begin
            state <= ST_LATCHED;
            fault_code <= latch_code(boost_f, hs_short_ev, ls_short_ev, pucheck_f, ot_f);
          end else if (nonlatch_cond) begin
            state <= ST_HOLD;
            fault_code <= FC_BIAS;
          end else if (state == ST_HOLD) begin
            state <= ST_RECOVER;
            rec_cnt <= 16'(RECOVER_COUNT - 1);
          end else if (state == ST_RECOVER) begin
            if (rec_cnt == 16'h0000) begin
              state <= ST_RUN;
              fault_code <= FC_NONE;
            end else begin
              rec_cnt <= rec_cnt - 16'h0001;
            end
          end
        end
        ST_LATCHED: begin
          state <= ST_LATCHED;
        end
      endcase
    end
  end

  // Outputs: any shutdown state stops switching and pulls the line low.
  assign switching_enable = (state == ST_RUN);
  assign temp_fault_line_low = (state != ST_RUN);
  assign fault_latched = (state == ST_LATCHED);
  // Cycle clamps only gate the switches and never touch line or code.
  assign hs_gate = switching_enable && hs_request && !valley_source_limit_hold && !peak_f;
  assign ls_gate = switching_enable && ls_request && !sink_f;

  // Valley limit blocks a new turn-on, not a pulse already running.
  logic hs_req_d;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_req_d <= 1'b0;
    end else begin
      hs_req_d <= hs_gate;
    end
  end
  assign valley_source_limit_hold = valley_f && !hs_req_d;

  // Interrupt status: bit per event, set wins over read-clear.
  logic [EV_BITS-1:0] ev;
  logic [EV_BITS-1:0] status;
  logic [EV_BITS-1:0] mask;
  logic status_rd;
  assign ev = {ot_f, ls_short_ev, hs_short_ev, peak_f, sink_f, valley_f, input_f, bias_f, boost_f};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status_rd ? '0 : status) | ev;
    end
  end
  assign irq = |(status & mask);

  // AXI4-Lite slave: one write and one read in flight.
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      mask <= MASK_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr == ADDR_MASK) begin
          if (w_strb[0]) mask[7:0] <= w_data[7:0];
          if (w_strb[1]) mask[8] <= w_data[8];
        // Control writes are taken but cannot lift a latch; only a power cycle can.
        end else if (aw_addr != ADDR_STATUS && aw_addr != ADDR_STATE && aw_addr != ADDR_CTRL) begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; a status read clears it as the data is captured.
  assign s_axi_arready = !s_axi_rvalid;
  assign status_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_STATUS);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        ADDR_STATUS: s_axi_rdata <= {23'h0, status};
        ADDR_MASK: s_axi_rdata <= {23'h0, mask};
        ADDR_STATE: s_axi_rdata <= {27'h0, state == ST_LATCHED, temp_fault_line_low, fault_code};
        ADDR_CTRL: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks.
  a_boost_code: assert property (@(posedge core_clk) disable iff (rst)
    boost_f && state != ST_LATCHED |=> fault_code == FC_BOOST && fault_latched) else $error("boost code");
  a_bias_nolatch: assert property (@(posedge core_clk) disable iff (rst)
    bias_f && !latch_ev && state != ST_LATCHED |=> state == ST_HOLD && fault_code == FC_BIAS) else $error("bias");
  a_input_nolatch: assert property (@(posedge core_clk) disable iff (rst)
    input_f && !latch_ev && state != ST_LATCHED |=> temp_fault_line_low && !fault_latched) else $error("input");
  a_clamp_noline: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_RUN && !latch_ev && !nonlatch_cond |=> !temp_fault_line_low) else $error("clamp line");
  a_sink_lsoff: assert property (@(posedge core_clk) disable iff (rst)
    sink_f |-> !ls_gate) else $error("sink");
  a_peak_hsoff: assert property (@(posedge core_clk) disable iff (rst)
    peak_f |-> !hs_gate) else $error("peak");
  a_hs_short: assert property (@(posedge core_clk) disable iff (rst)
    hs_short_ev && !boost_f && state != ST_LATCHED |=> fault_code == FC_HS_SHORT) else $error("hs short");
  a_pu_nocode: assert property (@(posedge core_clk) disable iff (rst)
    ls_short_ev && pucheck_f && !boost_f && !hs_short_ev && state != ST_LATCHED
    |=> fault_code == FC_NONE && fault_latched) else $error("pu code");
  a_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
    fault_latched |=> fault_latched) else $error("latch");
  a_ot_code: assert property (@(posedge core_clk) disable iff (rst)
    ot_f && !boost_f && !hs_short_ev && !ls_short_ev && state != ST_LATCHED
    |=> fault_code == FC_OVERTEMP && !switching_enable) else $error("ot");
  sequence s_cond_gone;
    state == ST_HOLD && !nonlatch_cond && !latch_ev;
  endsequence
  a_recover_wait: assert property (@(posedge core_clk) disable iff (rst)
    s_cond_gone |=> temp_fault_line_low [*8]) else $error("recover early");

endmodule // psfm_fault_manager

// ### psfm_controller_model.sv
`timescale 1ns/100ps
// Controller-side stand-in: a steady PWM pattern with dead time between the two requests.
module psfm_controller_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic hs_gate,
  input  wire logic ls_gate,
  output logic      hs_request,
  output logic      ls_request,
  output logic      hs_on,
  output logic      ls_on
);
  logic [3:0] phase;

  // Free-running phase counter; the gaps between the requests keep the switches from overlapping.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // Requests are decoded from the phase, so they change only just after an edge.
  assign hs_request = (phase < 4'h6);
  assign ls_request = (phase >= 4'h8) && (phase < 4'he);

  // Sensed switch state lags the drive by a cycle, as a real switch would.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_on <= 1'b0;
      ls_on <= 1'b0;
    end else begin
      hs_on <= hs_gate;
      ls_on <= ls_gate;
    end
  end
endmodule // psfm_controller_model

// ### power_stage_fault_manager_tb_top.sv
`timescale 1ns/100ps
module power_stage_fault_manager_tb_top;
  import psfm_pkg::*;
  localparam int RC = 20;
  localparam logic [8:0] LATCH = 9'h1c1;
  localparam logic [8:0] LINE = 9'h1c7;
  localparam logic [26:0] CODES = {3'h5, 3'h4, 3'h3, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2};
  logic        core_clk, rst, hs_request, ls_request, hs_on, ls_on, hs_gate, ls_gate;
  logic        switching_enable, temp_fault_line_low, fault_latched, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0]  ev;
  logic [2:0]  fault_code;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [33:0] e;
  logic [8:0]  m;
  int          fails, compares, n;

  psfm_fault_manager #(.RECOVER_COUNT(RC)) dut_u (
    .core_clk(core_clk), .rst(rst), .boost_supply_lockout(ev[0]), .bias_supply_lockout(ev[1]),
    .input_supply_lockout(ev[2]), .valley_source_limit(ev[3]), .sink_current_limit(ev[4]),
    .peak_source_limit(ev[5]), .high_side_short(ev[6]), .low_side_short(ev[7]), .overtemp(ev[8]),
    .powerup_check(ev[9]), .hs_on(hs_on), .ls_on(ls_on), .hs_request(hs_request),
    .ls_request(ls_request), .hs_gate(hs_gate), .ls_gate(ls_gate), .switching_enable(switching_enable),
    .temp_fault_line_low(temp_fault_line_low), .fault_code(fault_code), .fault_latched(fault_latched),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  psfm_controller_model ctl_u (.core_clk(core_clk), .rst(rst), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .hs_request(hs_request), .ls_request(ls_request), .hs_on(hs_on), .ls_on(ls_on));

  // Free-running 40 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Power cycle of the bias supply, modelled by the reset input.
  task automatic pwr();
    ev <= 10'h000;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask

  // The write holds each channel until its own ready, then waits for the response.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
  endtask

  // Bounded wait for the fault line to reach a level; the count comes back to the caller.
  task automatic wline(input logic v, output int c);
    c = 0;
    while (temp_fault_line_low !== v && c < RC + 100) begin @(posedge core_clk); c++; end
  endtask

  // Gates are compared while the partner is requesting each switch.
  task automatic gates(input logic h, input logic l);
    int c;
    c = 0;
    while (hs_request !== 1'b1 && c < 50) begin @(posedge core_clk); c++; end
    check("hs_gate", 32'(h), 32'(hs_gate));
    c = 0;
    while (ls_request !== 1'b1 && c < 50) begin @(posedge core_clk); c++; end
    check("ls_gate", 32'(l), 32'(ls_gate));
  endtask

  // Responses are matched against the oldest expectation as they appear.
  always @(posedge core_clk) begin
    if (bvalid && bready) check("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      e = rq.pop_front();
      check("rresp", 32'(e[33:32]), 32'(rresp));
      check("rdata", e[31:0], rdata);
    end
  end

  // A hang anywhere ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    test_done();
  end

  initial begin
    rst = 1'b1; ev = 10'h000; seed = 32'h38; fails = 0; compares = 0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    // One pass per fault source, each starting from a fresh power-up.
    for (int i = 0; i < 9; i++) begin
      pwr();
      gates(1'b1, 1'b1);
      ev[i] <= 1'b1;
      if (LINE[i]) wline(1'b1, n);
      else repeat (12) @(posedge core_clk);
      check("line", 32'(LINE[i]), 32'(temp_fault_line_low));
      check("code", 32'(CODES[3*i+:3]), 32'(fault_code));
      check("latched", 32'(LATCH[i]), 32'(fault_latched));
      check("run", 32'(!LINE[i]), 32'(switching_enable));
      gates(!LINE[i] && i != 3 && i != 5, !LINE[i] && i != 4);
      rd(ADDR_STATUS, 32'h1 << i, 2'h0);
      rd(ADDR_STATE, {27'h0, LATCH[i], LINE[i], CODES[3*i+:3]}, 2'h0);
      ev[i] <= 1'b0;
      if (LATCH[i]) begin
        repeat (8) @(posedge core_clk);
        wr(ADDR_CTRL, 32'h1, 2'h0);
        repeat (RC + 20) @(posedge core_clk);
        check("hold", 32'h1, 32'(fault_latched && temp_fault_line_low));
      end else if (LINE[i]) begin
        wline(1'b0, n);
        check("recover", 32'h1, 32'(n >= RC && n <= RC + 12));
        check("code", 32'(FC_NONE), 32'(fault_code));
        gates(1'b1, 1'b1);
      end else begin
        repeat (8) @(posedge core_clk);
        gates(1'b1, 1'b1);
      end
      $display("test %0d done", i);
    end
    // A short found by the power-up check latches but carries no code.
    pwr();
    ev[9] <= 1'b1;
    ev[7] <= 1'b1;
    wline(1'b1, n);
    check("code", 32'(FC_NONE), 32'(fault_code));
    check("latched", 32'h1, 32'(fault_latched));
    $display("test powerup done");
    // Mask round trip with a random value, then a masked and unmasked interrupt.
    pwr();
    seed = xs(seed);
    m = seed[8:0];
    wr(ADDR_MASK, {23'h0, m}, 2'h0);
    rd(ADDR_MASK, {23'h0, m}, 2'h0);
    wr(ADDR_MASK, 32'h0, 2'h0);
    ev[1] <= 1'b1;
    wline(1'b1, n);
    check("irq", 32'h0, 32'(irq));
    wr(ADDR_MASK, 32'h2, 2'h0);
    repeat (2) @(posedge core_clk);
    check("irq", 32'h1, 32'(irq));
    ev[1] <= 1'b0;
    wline(1'b0, n);
    rd(ADDR_STATUS, 32'h2, 2'h0);
    repeat (2) @(posedge core_clk);
    check("irq", 32'h0, 32'(irq));
    rd(ADDR_STATUS, 32'h0, 2'h0);
    // Unmapped places answer with a slave error.
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    repeat (4) @(posedge core_clk);
    $display("test registers done");
    test_done();
  end
endmodule // power_stage_fault_manager_tb_top
